// ===== rtc_pkg.sv
// constants for the calendar alarm comparator
package rtc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  RTC_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  RTC_OFS_INTMASK = 8'h04;
    localparam logic [7:0]  RTC_OFS_FLAG    = 8'h08;
    localparam logic [7:0]  RTC_OFS_MASKSEL = 8'h0c;
    localparam logic [7:0]  RTC_OFS_CLOCK   = 8'h10;
    localparam logic [7:0]  RTC_OFS_SYNC    = 8'h14;
    localparam logic [7:0]  RTC_OFS_ALARM   = 8'h18;

    localparam logic [31:0] RTC_RST_ALARM   = 32'h0000_0000;
    localparam logic [31:0] RTC_RST_CLOCK   = 32'h0000_0000;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int RTC_CTRL_EN           = 0;
    localparam int RTC_CTRL_CLR_ON_MATCH = 1;
    localparam int RTC_FLAG_ALARM        = 0;
    localparam int RTC_SYNC_ALARM        = 0;
    localparam int RTC_SEL_W             = 3;

    localparam int RTC_YEAR_LSB  = 26;
    localparam int RTC_YEAR_MSB  = 31;
    localparam int RTC_MONTH_LSB = 22;
    localparam int RTC_MONTH_MSB = 25;
    localparam int RTC_DAY_LSB   = 17;
    localparam int RTC_DAY_MSB   = 21;
    localparam int RTC_HOUR_LSB  = 12;
    localparam int RTC_HOUR_MSB  = 16;
    localparam int RTC_MIN_LSB   = 6;
    localparam int RTC_MIN_MSB   = 11;
    localparam int RTC_SEC_LSB   = 0;
    localparam int RTC_SEC_MSB   = 5;

    // field take part when the selection exceeds these; year only when it equals RTC_SEL_YEAR
    localparam logic [2:0] RTC_SEL_YEAR  = 3'h6;
    localparam logic [2:0] RTC_GT_MONTH  = 3'h4;
    localparam logic [2:0] RTC_GT_DAY    = 3'h3;
    localparam logic [2:0] RTC_GT_HOUR   = 3'h2;
    localparam logic [2:0] RTC_GT_MIN    = 3'h1;
    localparam logic [2:0] RTC_GT_SEC    = 3'h0;

    // calendar limits
    localparam logic [5:0] RTC_SEC_MAX   = 6'h3b;
    localparam logic [5:0] RTC_MIN_MAX   = 6'h3b;
    localparam logic [4:0] RTC_HOUR_MAX  = 5'h17;
    localparam logic [4:0] RTC_DAY_MAX   = 5'h1f;
    localparam logic [3:0] RTC_MONTH_MAX = 4'hc;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int RTC_CLK_PERIOD_NS  = 25;
    localparam int RTC_TICK_PERIOD_MS = 1000;
    localparam int RTC_TICK_CYCLES    = RTC_TICK_PERIOD_MS * 1000000 / RTC_CLK_PERIOD_NS;

endpackage : rtc_pkg

// ===== rtc_alarm.sv
// calendar counter with alarm comparator behind an apb slave
// Overview of operation
// - alarm value compared continuously with calendar value over enabled fields only
// - on match, alarm flag sets one counter cycle later
// - on match, calendar cleared only when clear-on-match bit is one
// - year bits 31:26 compared only when mask select equals 6
// - month bits 25:22 compared only when mask select above 4
// - day bits 21:17 compared only when mask select above 3
// - hour bits 16:12 compared only when mask select above 2
// - minute bits 11:6 compared only when mask select above 1
// - second bits 5:0 compared when select above 0; zero disables matching
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module rtc_alarm
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = RTC_TICK_CYCLES
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // ************************************************************
    // state
    // ************************************************************
    logic [1:0]           ctrl;
    logic                 int_mask;
    logic                 alarm_match_flag;
    logic [RTC_SEL_W-1:0] alarm_field_mask_select;
    logic [31:0]          calendar;
    logic [31:0]          alarm_zero_calendar_value;
    logic [31:0]          alarm_active;
    logic                 alarm_busy;
    logic                 match_pend;
    logic [31:0]          div_cnt;
    logic                 tick;
    logic [31:0]          care;
    logic                 cmp_hit;
    logic                 wr_en;
    logic                 setup;
    logic                 mapped;
    logic                 stall;
    logic [31:0]          rd_mux;
    logic [31:0]          next_calendar;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pready && pwrite && !pslverr;
    assign stall  = pwrite && paddr == RTC_OFS_ALARM && alarm_busy;
    assign mapped = paddr == RTC_OFS_CTRL || paddr == RTC_OFS_INTMASK
                 || paddr == RTC_OFS_FLAG || paddr == RTC_OFS_MASKSEL
                 || paddr == RTC_OFS_CLOCK || paddr == RTC_OFS_SYNC
                 || paddr == RTC_OFS_ALARM;

    // ************************************************************
    // apb slave
    // ************************************************************
    // one wait state; alarm writes wait while a previous one is in flight
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup ? 1'b0 : (psel && penable && !pready && !stall);
            pslverr <= psel && penable && !pready && !stall && !mapped;
            if (psel && penable && !pready && !stall)
            begin
                prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
            end
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            RTC_OFS_CTRL:    rd_mux[1:0] = ctrl;
            RTC_OFS_INTMASK: rd_mux[RTC_FLAG_ALARM] = int_mask;
            RTC_OFS_FLAG:    rd_mux[RTC_FLAG_ALARM] = alarm_match_flag;
            RTC_OFS_MASKSEL: rd_mux[RTC_SEL_W-1:0] = alarm_field_mask_select;
            RTC_OFS_CLOCK:   rd_mux = calendar;
            RTC_OFS_SYNC:    rd_mux[RTC_SYNC_ALARM] = alarm_busy;
            RTC_OFS_ALARM:   rd_mux = alarm_zero_calendar_value;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl                    <= 2'h0;
            int_mask                <= 1'b0;
            alarm_field_mask_select <= 3'h0;
        end
        else if (wr_en)
        begin
            if (paddr == RTC_OFS_CTRL)
                ctrl <= pwdata[1:0];
            if (paddr == RTC_OFS_INTMASK)
                int_mask <= pwdata[RTC_FLAG_ALARM];
            if (paddr == RTC_OFS_MASKSEL)
                alarm_field_mask_select <= pwdata[RTC_SEL_W-1:0];
        end
    end

    // ************************************************************
    // counter tick divider
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 32'h0000_0000;
            tick    <= 1'b0;
        end
        else
        begin
            tick    <= div_cnt == 32'(TICK_CYCLES - 1);
            div_cnt <= (div_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_cnt + 32'h1;
        end
    end

    // ************************************************************
    // alarm write synchronisation
    // ************************************************************
    // the comparator sees the new value only at a counter tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_zero_calendar_value <= RTC_RST_ALARM;
            alarm_active              <= RTC_RST_ALARM;
            alarm_busy                <= 1'b0;
        end
        else if (wr_en && paddr == RTC_OFS_ALARM)
        begin
            alarm_zero_calendar_value <= pwdata;
            alarm_busy                <= 1'b1;
        end
        else if (tick && alarm_busy)
        begin
            alarm_active <= alarm_zero_calendar_value;
            alarm_busy   <= 1'b0;
        end
    end

    // ************************************************************
    // comparator
    // ************************************************************
    always_comb
    begin
        care = 32'h0000_0000;
        care[RTC_YEAR_MSB:RTC_YEAR_LSB]   = {6{alarm_field_mask_select == RTC_SEL_YEAR}};
        care[RTC_MONTH_MSB:RTC_MONTH_LSB] = {4{alarm_field_mask_select > RTC_GT_MONTH}};
        care[RTC_DAY_MSB:RTC_DAY_LSB]     = {5{alarm_field_mask_select > RTC_GT_DAY}};
        care[RTC_HOUR_MSB:RTC_HOUR_LSB]   = {5{alarm_field_mask_select > RTC_GT_HOUR}};
        care[RTC_MIN_MSB:RTC_MIN_LSB]     = {6{alarm_field_mask_select > RTC_GT_MIN}};
        care[RTC_SEC_MSB:RTC_SEC_LSB]     = {6{alarm_field_mask_select > RTC_GT_SEC}};
    end

    // an all-zero mask would match always, so selection zero is off
    assign cmp_hit = (care != 32'h0000_0000)
                  && ((alarm_active & care) == (calendar & care));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_pend <= 1'b0;
        else if (tick)
            match_pend <= cmp_hit && ctrl[RTC_CTRL_EN] && !match_pend;
    end

    // set wins over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_match_flag <= 1'b0;
        else if (tick && match_pend)
            alarm_match_flag <= 1'b1;
        else if (wr_en && paddr == RTC_OFS_FLAG && pwdata[RTC_FLAG_ALARM])
            alarm_match_flag <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= alarm_match_flag && int_mask;
    end

    // ************************************************************
    // calendar counter
    // ************************************************************
    // month length is not tracked; every month runs to day 31
    always_comb
    begin
        next_calendar = calendar;
        if (calendar[RTC_SEC_MSB:RTC_SEC_LSB] < RTC_SEC_MAX)
            next_calendar[RTC_SEC_MSB:RTC_SEC_LSB] = calendar[RTC_SEC_MSB:RTC_SEC_LSB] + 6'h1;
        else
        begin
            next_calendar[RTC_SEC_MSB:RTC_SEC_LSB] = 6'h00;
            if (calendar[RTC_MIN_MSB:RTC_MIN_LSB] < RTC_MIN_MAX)
                next_calendar[RTC_MIN_MSB:RTC_MIN_LSB] = calendar[RTC_MIN_MSB:RTC_MIN_LSB] + 6'h1;
            else
            begin
                next_calendar[RTC_MIN_MSB:RTC_MIN_LSB] = 6'h00;
                if (calendar[RTC_HOUR_MSB:RTC_HOUR_LSB] < RTC_HOUR_MAX)
                    next_calendar[RTC_HOUR_MSB:RTC_HOUR_LSB] =
                        calendar[RTC_HOUR_MSB:RTC_HOUR_LSB] + 5'h1;
                else
                begin
                    next_calendar[RTC_HOUR_MSB:RTC_HOUR_LSB] = 5'h00;
                    if (calendar[RTC_DAY_MSB:RTC_DAY_LSB] < RTC_DAY_MAX)
                        next_calendar[RTC_DAY_MSB:RTC_DAY_LSB] =
                            calendar[RTC_DAY_MSB:RTC_DAY_LSB] + 5'h1;
                    else
                    begin
                        next_calendar[RTC_DAY_MSB:RTC_DAY_LSB] = 5'h01;
                        if (calendar[RTC_MONTH_MSB:RTC_MONTH_LSB] < RTC_MONTH_MAX)
                            next_calendar[RTC_MONTH_MSB:RTC_MONTH_LSB] =
                                calendar[RTC_MONTH_MSB:RTC_MONTH_LSB] + 4'h1;
                        else
                        begin
                            next_calendar[RTC_MONTH_MSB:RTC_MONTH_LSB] = 4'h1;
                            next_calendar[RTC_YEAR_MSB:RTC_YEAR_LSB] =
                                calendar[RTC_YEAR_MSB:RTC_YEAR_LSB] + 6'h1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            calendar <= RTC_RST_CLOCK;
        else if (wr_en && paddr == RTC_OFS_CLOCK)
            calendar <= pwdata;
        else if (tick && match_pend && ctrl[RTC_CTRL_CLR_ON_MATCH])
            calendar <= RTC_RST_CLOCK;
        else if (tick && ctrl[RTC_CTRL_EN])
            calendar <= next_calendar;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_hit_at_tick;
        tick && cmp_hit && ctrl[RTC_CTRL_EN] && !match_pend;
    endsequence

    // the hit is parked for one counter cycle; the flag may not rise yet
    sequence s_parked_next;
        ##1 (match_pend && !$rose(alarm_match_flag));
    endsequence

    property p_flag_after_hit;
        @(posedge pclk) disable iff (!presetn)
        s_hit_at_tick |-> s_parked_next;
    endproperty
    a_flag_after_hit: assert property (p_flag_after_hit) else $error("flag moved early");

    property p_flag_sets;
        @(posedge pclk) disable iff (!presetn)
        (tick && match_pend) |=> alarm_match_flag;
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("alarm flag not set");

    property p_flag_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(alarm_match_flag) |-> $past(tick) && $past(match_pend);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without match");

    property p_clear_on_match;
        @(posedge pclk) disable iff (!presetn)
        (tick && match_pend && ctrl[RTC_CTRL_CLR_ON_MATCH] && !wr_en)
            |=> calendar == RTC_RST_CLOCK;
    endproperty
    a_clear_on_match: assert property (p_clear_on_match) else $error("counter not cleared");

    property p_no_clear;
        @(posedge pclk) disable iff (!presetn)
        (tick && match_pend && !ctrl[RTC_CTRL_CLR_ON_MATCH] && ctrl[RTC_CTRL_EN] && !wr_en)
            |=> calendar == $past(next_calendar);
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("counter stopped on match");

    property p_sel_zero;
        @(posedge pclk) disable iff (!presetn)
        alarm_field_mask_select == 3'h0 |-> !cmp_hit;
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("match with selection zero");

    property p_year_only_six;
        @(posedge pclk) disable iff (!presetn)
        (alarm_field_mask_select == RTC_SEL_YEAR) && cmp_hit
            |-> alarm_active[RTC_YEAR_MSB:RTC_YEAR_LSB] == calendar[RTC_YEAR_MSB:RTC_YEAR_LSB]
             && alarm_active[RTC_SEC_MSB:RTC_SEC_LSB] == calendar[RTC_SEC_MSB:RTC_SEC_LSB];
    endproperty
    a_year_only_six: assert property (p_year_only_six) else $error("year compare wrong");

    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == RTC_OFS_FLAG && pwdata[RTC_FLAG_ALARM] && !(tick && match_pend))
            |=> !alarm_match_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        alarm_match_flag && !(wr_en && paddr == RTC_OFS_FLAG && pwdata[RTC_FLAG_ALARM])
            |=> alarm_match_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_sync_busy;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == RTC_OFS_ALARM) |=> alarm_busy;
    endproperty
    a_sync_busy: assert property (p_sync_busy) else $error("busy not raised");

    property p_sync_apply;
        @(posedge pclk) disable iff (!presetn)
        (tick && alarm_busy) |=> !alarm_busy && alarm_active == $past(alarm_zero_calendar_value);
    endproperty
    a_sync_apply: assert property (p_sync_apply) else $error("alarm not applied");

endmodule : rtc_alarm

// ===== tb_top.sv
// self-checking testbench for the calendar alarm comparator
`timescale 1ns/1ps
module tb_top
    import rtc_pkg::*;
;
    // ************************************************************
    // clock, reset and bus signals
    // ************************************************************
    localparam int TB_TICK = 8;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    int          mismatches;
    int          samples_checked;
    logic [31:0] rd;
    logic        er;

    rtc_alarm #(
        .TICK_CYCLES (TB_TICK)
    ) u_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            mismatches++;
            $display("wrong value %s: expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // master holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 200);
        if (n >= 200)
            chk("pready timeout", 32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr32

    function automatic logic [31:0] cal(input int y, input int mo, input int dy,
                                        input int h, input int mi, input int s);
        cal = (32'(y) << RTC_YEAR_LSB) | (32'(mo) << RTC_MONTH_LSB) | (32'(dy) << RTC_DAY_LSB)
            | (32'(h) << RTC_HOUR_LSB) | (32'(mi) << RTC_MIN_LSB) | (32'(s) << RTC_SEC_LSB);
    endfunction : cal

    // ************************************************************
    // one alarm case: field k differs, k 0 none, 1 min .. 5 year
    // ************************************************************
    task automatic run_case(input int sel, input int k, input logic clr);
        logic [31:0] c0;
        logic [31:0] al;
        logic        hit;
        int          n;
        // seconds start at 10 and the alarm waits at 20, so no roll-over in the window
        c0  = cal(5, 3, 7, 9, 11, 10);
        al  = cal(5 + (k == 5), 3 + (k == 4), 7 + (k == 3), 9 + (k == 2), 11 + (k == 1), 20);
        hit = (sel > 0) && !(k == 5 && sel == 6) && !(k == 4 && sel > 4)
            && !(k == 3 && sel > 3) && !(k == 2 && sel > 2) && !(k == 1 && sel > 1);
        wr32(RTC_OFS_CTRL, 32'h0000_0000);
        wr32(RTC_OFS_FLAG, 32'h0000_0001);
        wr32(RTC_OFS_MASKSEL, 32'(sel));
        wr32(RTC_OFS_CLOCK, c0);
        wr32(RTC_OFS_ALARM, al);
        wr32(RTC_OFS_CTRL, {30'h0, clr, 1'b1});
        apb(1'b0, RTC_OFS_ALARM, 32'h0, rd, er);
        chk("alarm readback", al, rd);
        n = 0;
        do
        begin
            apb(1'b0, RTC_OFS_SYNC, 32'h0, rd, er);
            n++;
        end
        while (rd[RTC_SYNC_ALARM] !== 1'b0 && n < 20);
        chk("sync busy", 32'h0, {31'h0, rd[RTC_SYNC_ALARM]});
        n = 0;
        do
        begin
            apb(1'b0, RTC_OFS_FLAG, 32'h0, rd, er);
            n++;
        end
        while (rd[RTC_FLAG_ALARM] !== 1'b1 && n < 60);
        chk("alarm flag", {31'h0, hit}, {31'h0, rd[RTC_FLAG_ALARM]});
        if (hit && sel == 6 && k == 0)
        begin
            apb(1'b0, RTC_OFS_CLOCK, 32'h0, rd, er);
            chk("calendar above seconds", clr ? 32'h0 : {6'h0, c0[31:6]}, {6'h0, rd[31:6]});
            wr32(RTC_OFS_FLAG, 32'h0000_0000);
            apb(1'b0, RTC_OFS_FLAG, 32'h0, rd, er);
            chk("flag after zero write", 32'h1, rd);
            repeat (3) @(posedge pclk);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr32(RTC_OFS_INTMASK, 32'h0000_0001);
            repeat (3) @(posedge pclk);
            chk("irq unmasked", 32'h1, {31'h0, irq});
            wr32(RTC_OFS_FLAG, 32'h0000_0001);
            repeat (3) @(posedge pclk);
            chk("irq after clear", 32'h0, {31'h0, irq});
            apb(1'b0, RTC_OFS_FLAG, 32'h0, rd, er);
            chk("flag after one write", 32'h0, rd);
            wr32(RTC_OFS_INTMASK, 32'h0000_0000);
        end
    endtask : run_case

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        mismatches      = 0;
        samples_checked = 0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk("irq at reset", 32'h0, {31'h0, irq});
        apb(1'b0, RTC_OFS_ALARM, 32'h0, rd, er);
        chk("alarm reset", RTC_RST_ALARM, rd);
        chk("mapped error", 32'h0, {31'h0, er});
        apb(1'b0, RTC_OFS_FLAG, 32'h0, rd, er);
        chk("flag reset", 32'h0, rd);
        // unmapped place: error with zero data, write ignored
        wr32(8'h1c, 32'hffff_ffff);
        apb(1'b0, 8'h1c, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test reset and map done");
        for (int s = 0; s < 8; s++)
        begin
            for (int k = 0; k < 6; k++)
                run_case(s, k, 1'b0);
            $display("test mask select %0d done", s);
        end
        run_case(6, 0, 1'b1);
        $display("test clear on match done");
        results();
    end

    initial
    begin
        // tests need about 10k cycles; 40k cycles leaves margin
        #1ms;
        mismatches++;
        results();
    end

endmodule : tb_top
